// *** rtcc_defs.svh ***
// Addresses, command fields, reset values and rates of the bus real-time clock.
// Assumes one 200 MHz clock and a synchronous register port.
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH
`define RTCC_A_HUND    5'h00
`define RTCC_A_HOUR    5'h01
`define RTCC_A_YEAR    5'h06
`define RTCC_A_STAT    5'h10
`define RTCC_A_CMD     5'h11
`define RTCC_A_MASK    5'h12
`define RTCC_CMD_TEST  5
`define RTCC_CMD_IEN   4
`define RTCC_CMD_RUN   3
`define RTCC_CMD_H24   2
`define RTCC_CMD_RST   6'h00
`define RTCC_MASK_RST  7'h00
`define RTCC_TICK_HZ   23'h000064
`define RTCC_F32K      23'h008000
`define RTCC_F1M       23'h100000
`define RTCC_F2M       23'h200000
`define RTCC_F4M       23'h400000
`define RTCC_MAX_HUND  7'h63
`define RTCC_MAX_HOUR  7'h17
`define RTCC_MAX_MS    7'h3B
`define RTCC_MAX_MON   7'h0C
`define RTCC_MAX_YEAR  7'h63
`define RTCC_MAX_DOW   7'h06
`define RTCC_HOUR_12   7'h0C
`endif

// *** rtcc_pkg.sv ***
// Types shared by the real-time clock modules.
// Assumes nothing beyond a SystemVerilog compiler.
package rtcc_pkg;
	typedef logic [7:0] rtcc_byte_t;
	typedef logic [6:0] rtcc_cnt_t;
	typedef enum logic [1:0] {
		RTCC_XT_32K = 2'b00,
		RTCC_XT_1M  = 2'b01,
		RTCC_XT_2M  = 2'b10,
		RTCC_XT_4M  = 2'b11
	} rtcc_freq_t;
endpackage

// *** rtcc_tick_if.sv ***
// Tick link between the clock core and the crystal divider.
// Assumes both ends run on i_clock.
`timescale 1ns/10ps
interface rtcc_tick_if;
	import rtcc_pkg::*;
	rtcc_freq_t freq;
	logic       test;
	logic       run;
	logic       tick;
	modport div (input freq, input test, input run, output tick);
	modport core (output freq, output test, output run, input tick);
endinterface

// *** rtcc_wrap_cnt.sv ***
// One wrapping time counter with load and carry.
// Assumes i_inc and i_load come from logic on i_clock.
`timescale 1ns/10ps
`include "rtcc_defs.svh"
module rtcc_wrap_cnt #(
	parameter logic [6:0] LO = 7'h00
) (
	input  wire logic               i_clock,
	input  wire logic               i_sys_rst,
	input  wire logic               i_inc,
	input  wire logic               i_load,
	input  wire rtcc_pkg::rtcc_cnt_t i_max,
	input  wire rtcc_pkg::rtcc_cnt_t i_val,
	output rtcc_pkg::rtcc_cnt_t      o_val,
	output logic                    o_wrap
);
	import rtcc_pkg::*;
	rtcc_cnt_t next_val;

	// Over-range values written by software also wrap on the next step
	assign o_wrap = i_inc & (o_val >= i_max);
	assign next_val = i_load ? i_val : o_wrap ? LO : i_inc ? o_val + 7'h01 : o_val;

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_val <= LO;
		else
			o_val <= next_val;
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	wrap_to_low_a:
		assert property (o_wrap && !i_load |=> o_val == LO) else $error("counter did not wrap");
	load_value_a:
		assert property (i_load |=> o_val == $past(i_val)) else $error("counter load lost");
endmodule

// *** rtcc_tick_div.sv ***
// Crystal pulse synchroniser and fractional divider to a 100 Hz tick.
// Assumes i_osc is a pin slower than half of i_clock.
`timescale 1ns/10ps
`include "rtcc_defs.svh"
module rtcc_tick_div (
	input  wire logic i_clock,
	input  wire logic i_sys_rst,
	input  wire logic i_osc,
	rtcc_tick_if.div  tk
);
	import rtcc_pkg::*;
	logic        osc_s1;
	logic        osc_s2;
	logic        osc_s3;
	logic [22:0] acc;
	logic [22:0] fdiv;
	logic [22:0] acc_sum;
	logic [22:0] next_acc;
	logic        osc_edge;
	logic        roll;
	logic        next_tick;

	assign osc_edge = osc_s2 & ~osc_s3;
	assign fdiv = (tk.freq == RTCC_XT_1M) ? `RTCC_F1M :
		(tk.freq == RTCC_XT_2M) ? `RTCC_F2M :
		(tk.freq == RTCC_XT_4M) ? `RTCC_F4M : `RTCC_F32K;
	// 32.768 kHz is no whole multiple of 100 Hz; the accumulator keeps the mean exact
	assign acc_sum = acc + `RTCC_TICK_HZ;
	assign roll = acc_sum >= fdiv;
	assign next_acc = !tk.run ? 23'h000000 : !osc_edge ? acc : roll ? acc_sum - fdiv : acc_sum;
	// tick from crystal, test mode steps every edge
	assign next_tick = tk.run & osc_edge & (tk.test | roll);

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			osc_s1  <= 1'b0;
			osc_s2  <= 1'b0;
			osc_s3  <= 1'b0;
			acc     <= 23'h000000;
			tk.tick <= 1'b0;
		end
		else
		begin
			osc_s1  <= i_osc;
			osc_s2  <= osc_s1;
			osc_s3  <= osc_s2;
			acc     <= next_acc;
			tk.tick <= next_tick;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	tick_needs_run_a:
		assert property (tk.tick |-> $past(tk.run) && $past(osc_edge)) else $error("tick while stopped");
	tick_on_roll_a:
		assert property (tk.run && !tk.test && osc_edge |=> tk.tick == $past(roll))
		else $error("tick not at divider roll");
	tick_seen_c: cover property (tk.tick ##[1:1000] tk.tick);
endmodule

// *** rtcc_top.sv ***
// Bus real-time clock: counters, snapshot, alarm, periodic interrupts, register port.
// Assumes the register port and latch strobe are on i_clock; osc and power-fail are pins.
`timescale 1ns/10ps
`include "rtcc_defs.svh"
module rtcc_top (
	input  wire logic                i_clock,
	input  wire logic                i_sys_rst,
	input  wire logic                i_osc,
	input  wire logic                i_power_fail,
	input  wire logic                i_mux_mode,
	input  wire logic                i_ale,
	input  wire logic [4:0]          i_addr,
	input  wire rtcc_pkg::rtcc_byte_t i_data,
	input  wire logic                i_wr,
	input  wire logic                i_rd,
	output rtcc_pkg::rtcc_byte_t      o_data,
	output logic                     o_data_oe,
	output logic                     o_irq
);
	import rtcc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic        pf_s1;
	logic        pf_s2;
	logic [4:0]  alat;
	logic [4:0]  addr;
	logic        wr_ok;
	logic        rd_ok;
	logic [5:0]  cmd;
	logic [6:0]  mask;
	logic [6:0]  stat;
	logic [6:0]  next_stat;
	logic [6:0]  clr;
	logic [6:0]  ev;
	logic        tick_d;
	logic        alm_match;
	logic        alm_hit;
	logic [4:0]  wr_h12;
	rtcc_cnt_t   wr_hour;
	rtcc_cnt_t   dim;
	logic        leap;
	logic [7:0]  inc;
	logic [7:0]  wrap;
	rtcc_cnt_t   cnt [8];
	rtcc_cnt_t   maxv [8];
	rtcc_cnt_t   snap [8];
	rtcc_byte_t  alm [8];
	rtcc_byte_t  rd_cnt;
	rtcc_byte_t  rdata;
	rtcc_tick_if tk ();

	function automatic rtcc_byte_t fmt(input logic [2:0] idx, input rtcc_cnt_t v,
		input logic h24);
		rtcc_cnt_t h12;
		h12 = (v >= `RTCC_HOUR_12) ? v - `RTCC_HOUR_12 : v;
		if (h12 == 7'h00)
			h12 = `RTCC_HOUR_12;
		if (idx == 3'h1 && !h24)
			fmt = {v >= `RTCC_HOUR_12, 2'b00, h12[4:0]};
		else
			fmt = {1'b0, v};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus access
	// latched or direct address
	assign addr = i_mux_mode ? alat : i_addr;
	// bus locked out on power loss
	assign wr_ok = i_wr & ~pf_s2;
	assign rd_ok = i_rd & ~pf_s2;

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pf_s1 <= 1'b1;
			pf_s2 <= 1'b1;
			alat  <= 5'h00;
		end
		else
		begin
			pf_s1 <= i_power_fail;
			pf_s2 <= pf_s1;
			if (i_ale)
				alat <= i_data[4:0];
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			cmd <= `RTCC_CMD_RST;
		else if (wr_ok && addr == `RTCC_A_CMD)
			cmd <= i_data[5:0];
	end

	assign tk.freq = rtcc_freq_t'(cmd[1:0]);
	assign tk.test = cmd[`RTCC_CMD_TEST];
	assign tk.run  = cmd[`RTCC_CMD_RUN];

	rtcc_tick_div u_div (
		.i_clock   (i_clock),
		.i_sys_rst (i_sys_rst),
		.i_osc     (i_osc),
		.tk        (tk.div)
	);

	////////////////////////////////////////////////////////////////////////////
	// Time and calendar counters
	// 12-hour writes carry PM in bit 7
	assign wr_h12  = (i_data[4:0] == 5'h0C) ? 5'h00 : i_data[4:0];
	assign wr_hour = cmd[`RTCC_CMD_H24] ? i_data[6:0] :
		{2'b00, wr_h12} + (i_data[7] ? `RTCC_HOUR_12 : 7'h00);

	// days in month with leap years
	assign leap = cnt[6][1:0] == 2'b00;
	assign dim = (cnt[4] == 7'h02) ? (leap ? 7'h1D : 7'h1C) :
		(cnt[4] == 7'h04 || cnt[4] == 7'h06 || cnt[4] == 7'h09 || cnt[4] == 7'h0B) ?
		7'h1E : 7'h1F;

	// Carry chain: hundredths, seconds, minutes, hours, date, month, year
	assign inc[0] = tk.tick;
	assign inc[3] = wrap[0];
	assign inc[2] = wrap[3];
	assign inc[1] = wrap[2];
	assign inc[5] = wrap[1];
	assign inc[7] = wrap[1];
	assign inc[4] = wrap[5];
	assign inc[6] = wrap[4];

	// limits up to a 99-year count
	assign maxv[0] = `RTCC_MAX_HUND;
	assign maxv[1] = `RTCC_MAX_HOUR;
	assign maxv[2] = `RTCC_MAX_MS;
	assign maxv[3] = `RTCC_MAX_MS;
	assign maxv[4] = `RTCC_MAX_MON;
	assign maxv[5] = dim;
	assign maxv[6] = `RTCC_MAX_YEAR;
	assign maxv[7] = `RTCC_MAX_DOW;

	// counter i sits at address i
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_cnt
			rtcc_wrap_cnt #(
				.LO ((gi == 4 || gi == 5) ? 7'h01 : 7'h00)
			) u_cnt (
				.i_clock   (i_clock),
				.i_sys_rst (i_sys_rst),
				.i_inc     (inc[gi]),
				.i_load    (wr_ok && addr == 5'(gi)),
				.i_max     (maxv[gi]),
				.i_val     ((gi == 1) ? wr_hour : i_data[6:0]),
				.o_val     (cnt[gi]),
				.o_wrap    (wrap[gi])
			);
		end
	endgenerate

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			for (int i = 0; i < 8; i++)
				snap[i] <= 7'h00;
		end
		else if (rd_ok && addr == `RTCC_A_HUND)
		begin
			for (int i = 0; i < 8; i++)
				snap[i] <= cnt[i];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Alarm store and comparator
	// alarm bytes at 08h..0Fh
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			for (int i = 0; i < 8; i++)
				alm[i] <= 8'h00;
		end
		else if (wr_ok && addr[4:3] == 2'b01)
			alm[addr[2:0]] <= i_data;
	end

	// Year is left out of the match; day of week is still compared like the other counters
	always_comb
	begin
		alm_match = 1'b1;
		for (int i = 0; i < 8; i++)
			if (i != 6 && alm[i] != fmt(3'(i), cnt[i], cmd[`RTCC_CMD_H24]))
				alm_match = 1'b0;
	end
	// Compare only right after a step, so one match gives one event
	assign alm_hit = tick_d & alm_match;

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask
	// six periodic sources
	assign ev = {wrap[1], wrap[2], wrap[3], wrap[0],
		tk.tick & (cnt[0] % 7'h0A == 7'h09), tk.tick, alm_hit};
	assign clr = (wr_ok && addr == `RTCC_A_STAT) ? i_data[6:0] : 7'h00;
	// sticky source bits, a new event wins over its clear
	assign next_stat = (stat & ~clr) | ev;

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			stat   <= 7'h00;
			mask   <= `RTCC_MASK_RST;
			tick_d <= 1'b0;
			o_irq  <= 1'b0;
		end
		else
		begin
			stat   <= next_stat;
			tick_d <= tk.tick;
			o_irq  <= cmd[`RTCC_CMD_IEN] & |(stat & mask);
			if (wr_ok && addr == `RTCC_A_MASK)
				mask <= i_data[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data
	assign rd_cnt = (addr[2:0] == 3'h0) ? {1'b0, cnt[0]} :
		fmt(addr[2:0], snap[addr[2:0]], cmd[`RTCC_CMD_H24]);
	assign rdata = (addr[4:3] == 2'b00) ? rd_cnt :
		(addr[4:3] == 2'b01) ? alm[addr[2:0]] :
		(addr == `RTCC_A_STAT) ? {|(stat & mask), stat} :
		(addr == `RTCC_A_MASK) ? {1'b0, mask} : 8'h00;

	// drive data for one cycle after a read
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_data    <= 8'h00;
			o_data_oe <= 1'b0;
		end
		else
		begin
			o_data    <= rd_ok ? rdata : 8'h00;
			o_data_oe <= rd_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	rd_answer_a:
		assert property (rd_ok |=> o_data_oe && o_data == $past(rdata)) else $error("no read answer");
	mux_latch_a:
		assert property (i_ale ##1 i_mux_mode |-> addr == $past(i_data[4:0]))
		else $error("latched address wrong");
	pf_no_read_a:
		assert property (i_rd && pf_s2 |=> !o_data_oe) else $error("read during power loss");
	pf_no_write_a:
		assert property (i_wr && pf_s2 |=> cmd == $past(cmd) && mask == $past(mask))
		else $error("write during power loss");
	year_wrap_a:
		assert property (inc[6] && cnt[6] == 7'h63 && !(wr_ok && addr == `RTCC_A_YEAR)
			|=> cnt[6] == 7'h00) else $error("year did not wrap at 99");
	leap_feb_a:
		assert property (cnt[4] == 7'h02 && inc[5] && cnt[5] == 7'h1C && !wr_ok
			|=> cnt[5] == (($past(cnt[6]) % 7'h04 == 7'h00) ? 7'h1D : 7'h01))
		else $error("February length wrong");
	hour_12_a:
		assert property (rd_ok && addr == `RTCC_A_HOUR && !cmd[`RTCC_CMD_H24]
			&& snap[1] <= 7'h17 |=> o_data[4:0] >= 5'h01 && o_data[4:0] <= 5'h0C)
		else $error("12-hour read out of range");
	snap_take_a:
		assert property (rd_ok && addr == `RTCC_A_HUND |=> snap[2] == $past(cnt[2]))
		else $error("snapshot not taken");
	snap_hold_a:
		assert property (!(rd_ok && addr == `RTCC_A_HUND) |=> $stable(snap[2]))
		else $error("snapshot changed without read");
	alarm_flag_a:
		assert property (alm_hit |=> stat[0]) else $error("alarm not flagged");
	period_flag_a:
		assert property (wrap[0] |=> stat[3] ##0 stat[1]) else $error("periodic flag missing");
	stat_sticky_a:
		assert property (stat[0] && !clr[0] |=> stat[0]) else $error("status bit lost");
	cmd_wonly_a:
		assert property (rd_ok && addr == `RTCC_A_CMD |=> o_data == 8'h00)
		else $error("command location readable");
	irq_level_a:
		assert property (cmd[`RTCC_CMD_IEN] && |(stat & mask) |=> o_irq)
		else $error("interrupt not raised");

	snap_read_c: cover property (rd_ok && addr == `RTCC_A_HUND ##2 rd_ok && addr == `RTCC_A_HOUR);
	alarm_c: cover property (alm_hit ##2 o_irq);
	sec_roll_c: cover property (wrap[0]);
endmodule

// *** rtcc_host_model.sv ***
// Host processor model for the clock's register port.
// Assumes the bench calls its tasks and shares i_clock with the clock.
`timescale 1ns/10ps
module rtcc_host_model (
	input  wire logic                 i_clock,
	input  wire rtcc_pkg::rtcc_byte_t i_rdata,
	input  wire logic                 i_rdata_oe,
	output logic                      o_ale,
	output logic [4:0]                o_addr,
	output rtcc_pkg::rtcc_byte_t      o_data,
	output logic                      o_wr,
	output logic                      o_rd
);
	import rtcc_pkg::*;
	initial
	begin
		o_ale  = 1'b0;
		o_addr = 5'h00;
		o_data = 8'h00;
		o_wr   = 1'b0;
		o_rd   = 1'b0;
	end
	task automatic wr(input logic [4:0] a, input rtcc_byte_t d);
		@(posedge i_clock);
		o_wr   <= 1'b1;
		o_addr <= a;
		o_data <= d;
		@(posedge i_clock);
		o_wr   <= 1'b0;
		o_addr <= ~a;
		o_data <= ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [8:0] q);
		@(posedge i_clock);
		o_rd   <= 1'b1;
		o_addr <= a;
		@(posedge i_clock);
		o_rd   <= 1'b0;
		o_addr <= ~a;
		#1 q = {i_rdata_oe, i_rdata};
	endtask
	task automatic ale(input logic [4:0] a);
		@(posedge i_clock);
		o_ale  <= 1'b1;
		o_data <= {3'h0, a};
		@(posedge i_clock);
		o_ale  <= 1'b0;
		o_data <= {3'h7, ~a};
	endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the bus real-time clock.
// Assumes the host model owns the register port; osc and power pins are driven here.
`timescale 1ns/10ps
module testbench;
	import rtcc_pkg::*;
	logic        i_clock;
	logic        i_sys_rst;
	logic        i_osc;
	logic        i_power_fail;
	logic        i_mux_mode;
	logic        i_ale;
	logic [4:0]  i_addr;
	rtcc_byte_t  i_data;
	logic        i_wr;
	logic        i_rd;
	rtcc_byte_t  o_data;
	logic        o_data_oe;
	logic        o_irq;
	int          n_errors;
	int          cmp_count;
	int          cyc;
	logic [8:0]  q;
	rtcc_byte_t  m;
	rtcc_byte_t  y;
	logic [23:0] e;
	logic [23:0] cal [5] = '{24'h04021C, 24'h05021C, 24'h630C1F, 24'h07041E, 24'h08021D};
	rtcc_byte_t  alm [8] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 8'h00, 8'h03};

	rtcc_top dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_osc(i_osc),
		.i_power_fail(i_power_fail), .i_mux_mode(i_mux_mode), .i_ale(i_ale),
		.i_addr(i_addr), .i_data(i_data), .i_wr(i_wr), .i_rd(i_rd),
		.o_data(o_data), .o_data_oe(o_data_oe), .o_irq(o_irq));
	rtcc_host_model host (.i_clock(i_clock), .i_rdata(o_data), .i_rdata_oe(o_data_oe),
		.o_ale(i_ale), .o_addr(i_addr), .o_data(i_data), .o_wr(i_wr), .o_rd(i_rd));

	initial
	begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end
	// Run needs under 6000 cycles; ceiling leaves wide margin
	always @(posedge i_clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [4:0] a, input rtcc_byte_t x);
		host.rd(a, q);
		chk(q, {1'b1, x});
	endtask
	task automatic irqchk(input logic x);
		repeat (2) @(posedge i_clock);
		#1 chk({8'h00, o_irq}, {8'h00, x});
	endtask
	// Fast crystal edges, two clocks per level, then let the sync settle
	task automatic pulses(input int n);
		repeat (n)
		begin
			@(posedge i_clock);
			i_osc <= 1'b1;
			repeat (2) @(posedge i_clock);
			i_osc <= 1'b0;
			@(posedge i_clock);
		end
		repeat (4) @(posedge i_clock);
	endtask
	// Crystal edges per 100 Hz tick, rounded up
	function automatic int f_edges(input int hz);
		return (hz + 99) / 100;
	endfunction
	// One crystal edge; test mode makes it one tick
	task automatic tick();
		@(posedge i_clock);
		i_osc <= 1'b1;
		repeat (4) @(posedge i_clock);
		i_osc <= 1'b0;
		repeat (6) @(posedge i_clock);
	endtask
	function automatic rtcc_byte_t f_h12(int h);
		return {h > 11, 2'h0, 5'((h % 12 == 0) ? 12 : h % 12)};
	endfunction
	// Day after {year, month, date}
	function automatic logic [23:0] f_next(logic [23:0] t);
		logic [7:0] lim;
		lim = (t[15:8] == 8'h02) ? ((t[17:16] == 2'h0) ? 8'h1D : 8'h1C) : 8'h1F;
		if (t[15:8] inside {8'h04, 8'h06, 8'h09, 8'h0B})
			lim = 8'h1E;
		if (t[7:0] < lim)
			return {t[23:8], t[7:0] + 8'h01};
		if (t[15:8] < 8'h0C)
			return {t[23:16], t[15:8] + 8'h01, 8'h01};
		return {(t[23:16] == 8'h63) ? 8'h00 : t[23:16] + 8'h01, 16'h0101};
	endfunction
	////////////////////////////////////////////////////////////////
	initial
	begin
		i_osc        = 1'b0;
		i_power_fail = 1'b0;
		i_mux_mode   = 1'b0;
		i_sys_rst    = 1'b1;
		repeat (20) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		repeat (4) @(posedge i_clock);
		void'($urandom(98));
		rdchk(5'h00, 8'h00);
		rdchk(5'h04, 8'h01);
		rdchk(5'h05, 8'h01);
		rdchk(5'h10, 8'h00);
		rdchk(5'h11, 8'h00);
		rdchk(5'h12, 8'h00);
		$display("test reset done");
		repeat (8)
		begin
			m = 8'($urandom_range(59));
			y = 8'($urandom_range(99));
			host.wr(5'h02, m);
			host.wr(5'h06, y);
			rdchk(5'h00, 8'h00);
			host.wr(5'h02, 8'h3B - m);
			rdchk(5'h02, m);
			rdchk(5'h06, y);
		end
		$display("test snapshot done");
		@(posedge i_clock);
		i_mux_mode <= 1'b1;
		host.ale(5'h03);
		host.wr(5'h1F, 8'h2A);
		host.ale(5'h00);
		rdchk(5'h1F, 8'h00);
		host.ale(5'h03);
		rdchk(5'h1F, 8'h2A);
		@(posedge i_clock);
		i_mux_mode <= 1'b0;
		rdchk(5'h1F, 8'h00);
		$display("test addressing done");
		@(posedge i_clock);
		i_power_fail <= 1'b1;
		repeat (4) @(posedge i_clock);
		host.wr(5'h03, 8'h11);
		host.rd(5'h03, q);
		chk(q, 9'h000);
		@(posedge i_clock);
		i_power_fail <= 1'b0;
		repeat (4) @(posedge i_clock);
		rdchk(5'h00, 8'h00);
		rdchk(5'h03, 8'h2A);
		$display("test power loss done");
		for (int h = 0; h < 24; h++)
		begin
			host.wr(5'h11, 8'h04);
			host.wr(5'h01, 8'(h));
			rdchk(5'h00, 8'h00);
			rdchk(5'h01, 8'(h));
			host.wr(5'h11, 8'h00);
			rdchk(5'h01, f_h12(h));
			host.wr(5'h01, f_h12(23 - h));
			host.wr(5'h11, 8'h04);
			rdchk(5'h00, 8'h00);
			rdchk(5'h01, 8'(23 - h));
		end
		$display("test hour format done");
		host.wr(5'h11, 8'h2C);
		foreach (cal[i])
		begin
			host.wr(5'h00, 8'h63);
			host.wr(5'h01, 8'h17);
			host.wr(5'h02, 8'h3B);
			host.wr(5'h03, 8'h3B);
			host.wr(5'h04, cal[i][15:8]);
			host.wr(5'h05, cal[i][7:0]);
			host.wr(5'h06, cal[i][23:16]);
			tick();
			e = f_next(cal[i]);
			rdchk(5'h00, 8'h00);
			rdchk(5'h01, 8'h00);
			rdchk(5'h03, 8'h00);
			rdchk(5'h04, e[15:8]);
			rdchk(5'h05, e[7:0]);
			rdchk(5'h06, e[23:16]);
		end
		$display("test calendar done");
		host.wr(5'h07, 8'h03);
		for (int a = 0; a < 8; a++)
			host.wr(5'(8 + a), alm[a]);
		host.wr(5'h10, 8'hFF);
		host.wr(5'h12, 8'h01);
		host.wr(5'h11, 8'h3C);
		irqchk(1'b0);
		tick();
		irqchk(1'b1);
		rdchk(5'h10, 8'h83);
		host.wr(5'h11, 8'h2C);
		irqchk(1'b0);
		host.wr(5'h11, 8'h3C);
		host.wr(5'h10, 8'h01);
		irqchk(1'b0);
		host.wr(5'h12, 8'h02);
		irqchk(1'b1);
		rdchk(5'h10, 8'h82);
		host.wr(5'h00, 8'h09);
		host.wr(5'h10, 8'hFF);
		tick();
		rdchk(5'h10, 8'h86);
		$display("test interrupts done");
		host.wr(5'h11, 8'h04);
		host.wr(5'h00, 8'h00);
		host.wr(5'h11, 8'h0C);
		pulses(f_edges(32768) - 1);
		rdchk(5'h00, 8'h00);
		pulses(1);
		rdchk(5'h00, 8'h01);
		host.wr(5'h11, 8'h04);
		host.wr(5'h11, 8'h0D);
		pulses(f_edges(32768));
		rdchk(5'h00, 8'h01);
		$display("test divider done");
		finish_test();
	end
endmodule
